// ===== design/esc_classifier.sv
// exception source classifier: ranks sources and reports the winner
`timescale 1ns/1ps
module esc_classifier #(
   parameter int NIRQ = 8
) (
   input  wire logic                      clk,
   input  wire logic                      resetn,
   input  wire logic                      warmResetReq,
   input  wire logic                      nmiPin,
   input  wire logic                      nmiSoft,
   input  wire logic                      excProcError,
   input  wire logic                      unmanaged,
   input  wire logic                      mpuViolation,
   input  wire logic                      fixedProtViolation,
   input  wire logic                      xnFetch,
   input  wire logic                      busErrPrecise,
   input  wire logic                      busErrImprecise,
   input  wire logic                      undefInstr,
   input  wire logic                      illegalUnaligned,
   input  wire logic                      invalidState,
   input  wire logic                      excReturnError,
   input  wire logic                      unalignedAccess,
   input  wire logic                      divByZero,
   input  wire logic                      trapUnalignedEn,
   input  wire logic                      trapDivZeroEn,
   input  wire logic                      svcExec,
   input  wire logic                      pendSvSet,
   input  wire logic                      timerZero,
   input  wire logic                      tickSoftSet,
   input  wire logic [NIRQ-1:0]           irqPin,
   input  wire logic [NIRQ-1:0]           irqSoftSet,
   input  wire logic [NIRQ-1:0]           irqEnable,
   input  wire logic [2:0]                faultEnable,
   input  wire logic                      svcEnable,
   input  wire logic                      pendSvEnable,
   input  wire logic                      tickEnable,
   input  wire logic [8*(6+NIRQ)-1:0]     prioWrData,
   input  wire logic                      prioWrEn,
   input  wire logic                      entryAck,
   input  wire logic                      handlerDone,
   output logic                           coreHalt,
   output logic                           resetFetch,
   output logic [31:0]                    fetchAddr,
   output logic                           privThread,
   output logic                           excValid,
   output logic [esc_pkg::EXC_W-1:0]      excNumber,
   output logic [31:0]                    excVector,
   output logic                           excSync,
   output logic                           graceInstr,
   output logic [esc_pkg::EXC_W-1:0]      activeExcNum
);
   localparam int NUM_PRIO = 6 + NIRQ;   // mpf, bef, iuf, svc, psr, tick, irqs
   localparam int NSRC = esc_pkg::NUM_SYS + NIRQ;

   // refuse counts that would push the highest exception number past 255
   if (NIRQ < 1 || NIRQ > 240) begin : gBadNirq
      $error("NIRQ out of range");
   end

   // --------------------------------------------------------------
   // request synchronisation
   // --------------------------------------------------------------
   logic [NIRQ-1:0] irqSync;
   logic            nmiSync;
   logic            warmSync;

   esc_sync3 #(.W(NIRQ + 2)) uSync (
      .clk    (clk),
      .resetn (resetn),
      .din    ({irqPin, nmiPin, warmResetReq}),
      .dout   ({irqSync, nmiSync, warmSync})
   );

   // --------------------------------------------------------------
   // reset sequencing
   // --------------------------------------------------------------
   logic inResetQ;
   logic fetchQ;

   // warm request re-enters reset like power-up; halt holds while in reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         inResetQ <= 1'b1;
         fetchQ   <= 1'b0;
      end else begin
         inResetQ <= warmSync;
         fetchQ   <= inResetQ && !warmSync;
      end
   end

   assign coreHalt   = !resetn || inResetQ;
   assign resetFetch = fetchQ;
   assign fetchAddr  = esc_pkg::VEC_RESET;

   // privileged thread after reset; nothing here clears it, clearing stays core's job
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         privThread <= 1'b1;
      end else if (inResetQ) begin
         privThread <= 1'b1;
      end
   end

   // --------------------------------------------------------------
   // priorities
   // --------------------------------------------------------------
   logic [8*NUM_PRIO-1:0] prioQ;

   // every configurable priority starts at zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prioQ <= '0;
      end else if (inResetQ) begin
         prioQ <= '0;
      end else if (prioWrEn) begin
         prioQ <= prioWrData;
      end
   end

   // --------------------------------------------------------------
   // pending state
   // --------------------------------------------------------------
   logic [NSRC-1:0] pendQ;
   logic [NSRC-1:0] raise;
   logic [NSRC-1:0] enab;
   logic            handling;
   logic [esc_pkg::EXC_W-1:0] winNum;

   // raise conditions per source; reserved numbers never raise
   always_comb begin
      raise = '0;
      raise[2]  = nmiSync || nmiSoft;
      raise[3]  = excProcError || unmanaged;
      raise[4]  = mpuViolation || fixedProtViolation || xnFetch;
      raise[5]  = busErrPrecise || busErrImprecise;
      raise[6]  = undefInstr || illegalUnaligned || invalidState
                  || excReturnError
                  || (unalignedAccess && trapUnalignedEn)
                  || (divByZero && trapDivZeroEn);
      raise[11] = svcExec;
      raise[14] = pendSvSet;
      raise[15] = timerZero || tickSoftSet;
      raise[NSRC-1:16] = irqSync | irqSoftSet;
   end

   // fixed exceptions cannot be disabled; reserved slots stay off
   always_comb begin
      enab = '0;
      enab[2]  = 1'b1;
      enab[3]  = 1'b1;
      enab[6:4] = faultEnable;
      enab[11] = svcEnable;
      enab[14] = pendSvEnable;
      enab[15] = tickEnable;
      enab[NSRC-1:16] = irqEnable;
   end

   // raise wins over clear by acceptance in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pendQ <= '0;
      end else if (inResetQ) begin
         pendQ <= '0;
      end else begin
         for (int i = 0; i < NSRC; i++) begin
            if (raise[i]) begin
               pendQ[i] <= 1'b1;
            end else if (entryAck && excValid && winNum == i[8:0]) begin
               pendQ[i] <= 1'b0;
            end
         end
      end
   end

   // --------------------------------------------------------------
   // bus error kind
   // --------------------------------------------------------------
   logic busPreciseQ;

   // remember what pended the bus error: the precise level may be gone by entry
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         busPreciseQ <= 1'b0;
      end else if (inResetQ) begin
         busPreciseQ <= 1'b0;
      end else if (busErrPrecise) begin
         busPreciseQ <= 1'b1;
      end else if (busErrImprecise && !pendQ[5]) begin
         busPreciseQ <= 1'b0;
      end
   end

   // --------------------------------------------------------------
   // arbitration
   // --------------------------------------------------------------
   function automatic logic [9:0] rankOf(input int n, input logic [8*NUM_PRIO-1:0] p);
      logic [9:0] r;
      r = 10'h000;
      if (n == 2) begin
         r = esc_pkg::RANK_NMI;
      end else if (n == 3) begin
         r = esc_pkg::RANK_ESCF;
      end else if (n >= 4 && n <= 6) begin
         r = {2'b00, p[8*(n-4) +: 8]};
      end else if (n == 11) begin
         r = {2'b00, p[8*3 +: 8]};
      end else if (n == 14) begin
         r = {2'b00, p[8*4 +: 8]};
      end else if (n == 15) begin
         r = {2'b00, p[8*5 +: 8]};
      end else if (n >= 16) begin
         r = {2'b00, p[8*(n-10) +: 8]};
      end
      return r;
   endfunction

   logic [9:0] winRank;
   logic       winFound;

   // scan upward; strict less-than keeps the lowest number on ties
   // a linear chain: small area, but depth grows with the interrupt count
   always_comb begin
      winFound = 1'b0;
      winNum   = '0;
      winRank  = 10'h000;
      for (int i = 2; i < NSRC; i++) begin
         if (pendQ[i] && enab[i]) begin
            if (!winFound || $signed(rankOf(i, prioQ)) < $signed(winRank)) begin
               winFound = 1'b1;
               winNum   = i[8:0];
               winRank  = rankOf(i, prioQ);
            end
         end
      end
   end

   // --------------------------------------------------------------
   // active tracking
   // --------------------------------------------------------------
   logic [9:0] actRankQ;

   // nmi handler is only left by reset or its own completion
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         activeExcNum <= '0;
         actRankQ     <= 10'h000;
      end else if (inResetQ) begin
         activeExcNum <= '0;
      end else if (entryAck && excValid) begin
         activeExcNum <= winNum;
         actRankQ     <= winRank;
      end else if (handlerDone) begin
         activeExcNum <= '0;
      end
   end

   assign handling = activeExcNum != '0;

   // --------------------------------------------------------------
   // outputs to the core
   // --------------------------------------------------------------
   // only strictly higher rank preempts, so nothing ranks above an active nmi
   assign excValid = winFound && !inResetQ
                     && (!handling || $signed(winRank) < $signed(actRankQ));
   assign excNumber = winNum;
   assign excVector = {21'h000000, winNum, 2'b00};

   // sync classes: memory protection, usage, supervisor call, precise bus error
   assign excSync = excValid && (winNum == esc_pkg::EXC_MPF || winNum == esc_pkg::EXC_IUF
                    || winNum == esc_pkg::EXC_SVC
                    || (winNum == esc_pkg::EXC_BEF && busPreciseQ));
   // asynchronous entries allow one more instruction to retire first
   assign graceInstr = excValid && !excSync;
endmodule

// ===== design/esc_pkg.sv
// shared constants for the exception source classifier
package esc_pkg;
   localparam int EXC_W = 9;                        // exception number width
   localparam logic [8:0] EXC_RESET  = 9'h001;
   localparam logic [8:0] EXC_NMI    = 9'h002;
   localparam logic [8:0] EXC_ESCF   = 9'h003;
   localparam logic [8:0] EXC_MPF    = 9'h004;
   localparam logic [8:0] EXC_BEF    = 9'h005;
   localparam logic [8:0] EXC_IUF    = 9'h006;
   localparam logic [8:0] EXC_SVC    = 9'h00b;
   localparam logic [8:0] EXC_PSR    = 9'h00e;
   localparam logic [8:0] EXC_TICK   = 9'h00f;
   localparam logic [8:0] EXC_IRQ0   = 9'h010;
   localparam logic [31:0] VEC_RESET = 32'h00000004;
   localparam logic [31:0] VEC_NMI   = 32'h00000008;
   localparam logic [31:0] VEC_ESCF  = 32'h0000000c;
   localparam logic [31:0] VEC_IRQ0  = 32'h00000040;
   localparam int PRIO_W = 8;                       // configurable priority range 0-255
   localparam logic [9:0] RANK_RESET = 10'h3fd;     // -3 as signed 10-bit
   localparam logic [9:0] RANK_NMI   = 10'h3fe;     // -2
   localparam logic [9:0] RANK_ESCF  = 10'h3ff;     // -1
   localparam logic [7:0] PRIO_RST   = 8'h00;
   localparam int NUM_SYS = 16;
   typedef enum logic [1:0] {ESC_ACT_NONE, ESC_ACT_SYNC, ESC_ACT_ASYNC} esc_act_t;
endpackage

// ===== design/esc_sync3.sv
// three-stage synchroniser for pin-level requests
`timescale 1ns/1ps
module esc_sync3 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1Q, s2Q, s3Q;

   // first stage feeds only the second; change counts when second and third agree
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1Q  <= '0;
         s2Q  <= '0;
         s3Q  <= '0;
         dout <= '0;
      end else begin
         s1Q <= din;
         s2Q <= s1Q;
         s3Q <= s2Q;
         for (int i = 0; i < W; i++) begin
            if (s2Q[i] == s3Q[i]) begin
               dout[i] <= s3Q[i];
            end
         end
      end
   end
endmodule

// ===== testbench/esc_classifier_props.sv
// assertion checker for the exception source classifier
`timescale 1ns/1ps
module esc_classifier_props (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        nmiSoft,
   input wire logic        entryAck,
   input wire logic        handlerDone,
   input wire logic        coreHalt,
   input wire logic        resetFetch,
   input wire logic [31:0] fetchAddr,
   input wire logic        privThread,
   input wire logic        excValid,
   input wire logic [8:0]  excNumber,
   input wire logic [31:0] excVector,
   input wire logic        excSync,
   input wire logic        graceInstr,
   input wire logic [8:0]  activeExcNum
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // halt is checked inside reset, so this one is never disabled
   property p_halt; disable iff (1'b0) !resetn |-> coreHalt; endproperty
   a_halt: assert property (p_halt) else $error("core runs in reset");
   property p_fetch; resetFetch |-> fetchAddr == 32'h00000004 && privThread; endproperty
   a_fetch: assert property (p_fetch) else $error("bad restart");
   property p_nmi;
      nmiSoft && !coreHalt && !entryAck && activeExcNum != 9'h002
         |=> excValid && excNumber == 9'h002;
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi not first");
   property p_vec; excValid |-> excVector == {21'h0, excNumber, 2'b00}; endproperty
   a_vec: assert property (p_vec) else $error("bad vector");
   property p_resv;
      excValid |-> excNumber != 9'h000 && !(excNumber inside {[9'h007:9'h00a], 9'h00c, 9'h00d});
   endproperty
   a_resv: assert property (p_resv) else $error("reserved number");
   property p_sync; excValid && excNumber inside {9'h004, 9'h006, 9'h00b} |-> excSync; endproperty
   a_sync: assert property (p_sync) else $error("should be sync");
   property p_async;
      excValid && (excNumber >= 9'h00e || excNumber == 9'h002) |-> !excSync && graceInstr;
   endproperty
   a_async: assert property (p_async) else $error("should be async");
   property p_ack; entryAck && excValid |=> activeExcNum == $past(excNumber); endproperty
   a_ack: assert property (p_ack) else $error("active not taken");
   property p_done; handlerDone && !entryAck |=> activeExcNum == 9'h000; endproperty
   a_done: assert property (p_done) else $error("active not cleared");
   c_nmi: cover property (excValid && excNumber == 9'h002);
   c_irq: cover property (excValid && excNumber >= 9'h010);
   c_fetch: cover property (resetFetch);
endmodule
bind esc_classifier esc_classifier_props u_props (.clk, .resetn, .nmiSoft, .entryAck,
   .handlerDone, .coreHalt, .resetFetch, .fetchAddr, .privThread, .excValid, .excNumber,
   .excVector, .excSync, .graceInstr, .activeExcNum);

// ===== testbench/esc_periph_model.sv
// peripheral and system timer model raising requests into the classifier
`timescale 1ns/1ps
module esc_periph_model #(
   parameter int NIRQ   = 2,
   parameter int RELOAD = 4
) (
   input  wire logic            clk,
   input  wire logic            resetn,
   input  wire logic [NIRQ-1:0] irqReq,
   input  wire logic            timerRun,
   output logic      [NIRQ-1:0] irqPin,
   output logic                 timerZero
);
   logic [7:0] cnt_q;
   // peripheral lines rise at any time, unrelated to instruction flow
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irqPin <= '0;
      end else begin
         irqPin <= irqReq;
      end
   end
   // countdown only while running, so no stray ticks between tests
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 8'(RELOAD);
      end else if (timerRun) begin
         cnt_q <= (cnt_q == 8'h00) ? 8'(RELOAD) : cnt_q - 8'h01;
      end
   end
   assign timerZero = timerRun && cnt_q == 8'h00;
endmodule

// ===== testbench/testbench.sv
// self-checking testbench for the exception source classifier
`timescale 1ns/1ps
module testbench;
   localparam int NIRQ = 2;
   logic        clk, resetn, warm, nmiS, nmiP, pend, tickS, prioWr, ack, done, trapU, trapD, run;
   logic [13:0] flt;
   logic [2:0]  fEn;
   logic [1:0]  irqS, irqEn, irqReq, irqPin;
   logic [63:0] prio;
   logic        halt, rFetch, priv, vld, sync, grace, tZero;
   logic [31:0] fAddr, vec;
   logic [8:0]  num, act;
   int          n_fail = 0;
   int          n_tests = 0;
   esc_periph_model #(.NIRQ(NIRQ), .RELOAD(4)) u_periph (.clk(clk), .resetn(resetn),
      .irqReq(irqReq), .timerRun(run), .irqPin(irqPin), .timerZero(tZero));
   esc_classifier #(.NIRQ(NIRQ)) u_dut (.clk(clk), .resetn(resetn), .warmResetReq(warm),
      .nmiPin(nmiP), .nmiSoft(nmiS), .excProcError(flt[0]), .unmanaged(flt[1]),
      .mpuViolation(flt[2]), .fixedProtViolation(flt[3]), .xnFetch(flt[4]),
      .busErrPrecise(flt[5]), .busErrImprecise(flt[6]), .undefInstr(flt[7]),
      .illegalUnaligned(flt[8]), .invalidState(flt[9]), .excReturnError(flt[10]),
      .svcExec(flt[11]), .unalignedAccess(flt[12]), .divByZero(flt[13]),
      .trapUnalignedEn(trapU), .trapDivZeroEn(trapD), .pendSvSet(pend), .timerZero(tZero),
      .tickSoftSet(tickS), .irqPin(irqPin), .irqSoftSet(irqS), .irqEnable(irqEn),
      .faultEnable(fEn), .svcEnable(1'b1), .pendSvEnable(1'b1), .tickEnable(1'b1),
      .prioWrData(prio), .prioWrEn(prioWr), .entryAck(ack), .handlerDone(done),
      .coreHalt(halt), .resetFetch(rFetch), .fetchAddr(fAddr), .privThread(priv),
      .excValid(vld), .excNumber(num), .excVector(vec), .excSync(sync),
      .graceInstr(grace), .activeExcNum(act));
   // ----------------------------
   // shared tasks
   // ----------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // fault inputs drop at the ack edge so a held level cannot re-pend
   task automatic take(input logic [8:0] n);
      chk(vld, 1'b1);
      chk(num, n);
      chk(vec, {21'h0, n, 2'b00});
      ack = 1'b1;
      flt = '0;
      @(negedge clk);
      ack = 1'b0;
      chk(act, n);
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
   endtask
   task automatic t_reset();
      resetn = 1'b0;
      repeat (12) @(negedge clk);
      chk(halt, 1'b1);
      resetn = 1'b1;
      for (int i = 0; i < 20 && rFetch !== 1'b1; i++) @(negedge clk);
      chk(rFetch, 1'b1);
      chk(fAddr, 32'h00000004);
      chk(priv, 1'b1);
      $display("reset test done");
   endtask
   task automatic t_nmi();
      nmiS = 1'b1;
      flt[0] = 1'b1;
      @(negedge clk);
      nmiS = 1'b0;
      take(9'h002);
      take(9'h003);
      $display("nmi test done");
   endtask
   task automatic t_faults();
      logic [8:0] expN [12] = '{3, 3, 4, 4, 4, 5, 5, 6, 6, 6, 6, 11};
      for (int i = 0; i < 12; i++) begin
         flt = 14'(1) << i;
         @(negedge clk);
         if (i > 1) chk(sync, i != 6);
         take(expN[i]);
      end
      flt = 14'h3000;
      repeat (2) @(negedge clk);
      chk(vld, 1'b0);
      for (int k = 0; k < 2; k++) begin
         trapU = (k == 0);
         trapD = (k == 1);
         flt[12 + k] = 1'b1;
         @(negedge clk);
         take(9'h006);
      end
      trapD = 1'b0;
      // a disabled fault stays pending and wins once enabled again
      fEn = 3'h6;
      flt[2] = 1'b1;
      repeat (2) @(negedge clk);
      chk(vld, 1'b0);
      fEn = 3'h7;
      @(negedge clk);
      take(9'h004);
      $display("fault test done");
   endtask
   // tick prio 0, irq0 prio 1, pendable prio 2: order 15, 16, 14
   task automatic t_rank();
      prio = 64'h0001000200000000;
      prioWr = 1'b1;
      @(negedge clk);
      prioWr = 1'b0;
      {pend, tickS, irqS} = 4'b1101;
      @(negedge clk);
      {pend, tickS, irqS} = 4'b0000;
      take(9'h00f);
      take(9'h010);
      take(9'h00e);
      irqS = 2'b10;
      @(negedge clk);
      irqS = 2'b00;
      chk(vld, 1'b0);
      irqEn = 2'b11;
      @(negedge clk);
      take(9'h011);
      $display("rank test done");
   endtask
   // pin levels must stand until the second and third sync stages agree
   task automatic t_pins();
      irqReq = 2'b01;
      nmiP = 1'b1;
      repeat (3) @(negedge clk);
      irqReq = 2'b00;
      nmiP = 1'b0;
      repeat (8) @(negedge clk);
      take(9'h002);
      chk(grace, 1'b1);
      take(9'h010);
      run = 1'b1;
      for (int i = 0; i < 20 && vld !== 1'b1; i++) @(negedge clk);
      run = 1'b0;
      take(9'h00f);
      $display("pin test done");
   endtask
   // after warm reset priorities are 0 again, so pendable beats irq0
   task automatic t_warm();
      warm = 1'b1;
      for (int i = 0; i < 10 && halt !== 1'b1; i++) @(negedge clk);
      chk(halt, 1'b1);
      warm = 1'b0;
      for (int i = 0; i < 20 && rFetch !== 1'b1; i++) @(negedge clk);
      chk(rFetch, 1'b1);
      {pend, irqS} = 3'b101;
      @(negedge clk);
      {pend, irqS} = 3'b000;
      take(9'h00e);
      take(9'h010);
      $display("warm reset test done");
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      {resetn, warm, nmiS, nmiP, pend, tickS, prioWr, ack, done, trapU, trapD, run} = '0;
      {flt, irqS, irqReq, prio} = '0;
      irqEn = 2'b01;
      fEn = 3'h7;
      t_reset();
      t_nmi();
      t_faults();
      t_rank();
      t_pins();
      t_warm();
      report_and_stop();
   end
   // the whole run needs some 120 cycles; this allows far more
   initial begin
      #200000;
      n_fail++;
      report_and_stop();
   end
endmodule
